// ---- verilog/mpmc_pkg.sv ----
package mpmc_pkg;

  // ******************************************************
  // Timing
  // ******************************************************
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned CONFIRM_SEC = 5;
  localparam int unsigned CONFIRM_CYC = CONFIRM_SEC * CLK_HZ;
  localparam int unsigned OFFTAPE_LAG_MS = 240;
  localparam int unsigned LAG_SAMPLES_48K = (48000 * OFFTAPE_LAG_MS) / 1000;
  localparam int unsigned FLASH_CYC = CLK_HZ / 4;

  // ******************************************************
  // Register map (word offsets as byte addresses)
  // ******************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RATE = 8'h04;
  localparam logic [7:0] OFS_PATCH = 8'h08;
  localparam logic [7:0] OFS_INMON = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_ARM = 8'h14;
  localparam logic [7:0] OFS_MASTER = 8'h18;
  localparam logic [7:0] OFS_CLKOK = 8'h1C;
  localparam logic [7:0] OFS_MIXSRC = 8'h20;
  localparam logic [7:0] OFS_MIXLVL = 8'h40;
  // Identity patch: channel n taken from track n
  localparam logic [23:0] PATCH_RST = 24'hFAC688;
  localparam logic [6:0] LEVEL_RST = 7'h7F;
  localparam logic [6:0] PAN_CENTER = 7'h40;

  // Track rate codes
  typedef enum logic [1:0] {MPMC_BASE, MPMC_DUAL, MPMC_QUAD, MPMC_OFF}
    mpmc_rate_t;

  // Mix input source
  typedef enum logic [1:0] {MPMC_TAPE, MPMC_SLOT, MPMC_DIG, MPMC_NONE}
    mpmc_src_t;

  // Word-sync clock sources, in key stepping order
  typedef enum logic [2:0] {MPMC_INT, MPMC_WORD, MPMC_VIDEO, MPMC_AES,
    MPMC_SLOTCK} mpmc_clk_t;

  typedef struct packed {
    mpmc_src_t src;
    logic [2:0] chan;
  } mpmc_mixsel_t;

  typedef struct packed {
    logic [6:0] level;
    logic [6:0] pan;
  } mpmc_mixch_t;

  // Front-panel key pulses
  typedef struct packed {
    logic confidence;
    logic mixdown;
    logic clock;
    logic escape;
    logic [7:0] arm;
  } mpmc_keys_t;

endpackage

// ---- verilog/mpmc_delay.sv ----
`timescale 1ns/10ps
// ******************************************************
// Sample delay line for off-tape lag
// ******************************************************
module mpmc_delay #(
  parameter int W = 24,
  parameter int DEPTH = 64
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic strobe,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] ptr_reg;
  logic [AW-1:0] ptr_next;

  // Wrap at DEPTH, which need not be a power of two
  assign ptr_next = (ptr_reg == AW'(DEPTH - 1)) ? '0 : ptr_reg + 1'b1;

  // Pointer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_reg <= '0;
    end else if (strobe) begin
      ptr_reg <= ptr_next;
    end
  end

  // Read-before-write gives exactly DEPTH samples of lag
  always_ff @(posedge clk) begin
    if (strobe) begin
      dout <= mem[ptr_reg];
      mem[ptr_reg] <= din;
    end
  end
endmodule

// ---- verilog/mpmc_mixer.sv ----
`timescale 1ns/10ps
// ******************************************************
// Serial stereo mix summer, one input per cycle
// ******************************************************
module mpmc_mixer #(
  parameter int W = 24
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic strobe,
  input wire logic [8*W-1:0] mix_in,
  input wire mpmc_pkg::mpmc_mixch_t [7:0] chan_cfg,
  input wire logic [6:0] master,
  output logic [W-1:0] left,
  output logic [W-1:0] right
);
  localparam int AW = W + 16;
  logic [3:0] idx_reg;
  logic signed [AW-1:0] acc_l_reg;
  logic signed [AW-1:0] acc_r_reg;
  logic signed [W-1:0] smp;
  logic signed [W+7:0] lvl;
  logic signed [AW-1:0] part_l;
  logic signed [AW-1:0] part_r;
  logic signed [AW+7:0] out_l;
  logic signed [AW+7:0] out_r;
  logic [2:0] sel;

  // Level then pan: L gets (127-pan), R gets pan
  assign sel = idx_reg[2:0];
  assign smp = mix_in[sel*W +: W];
  assign lvl = smp * $signed({1'b0, chan_cfg[sel].level});
  assign part_l = AW'(lvl * $signed({1'b0, 7'h7F - chan_cfg[sel].pan}));
  assign part_r = AW'(lvl * $signed({1'b0, chan_cfg[sel].pan}));
  assign out_l = acc_l_reg * $signed({1'b0, master});
  assign out_r = acc_r_reg * $signed({1'b0, master});

  // Eight accumulate steps follow each sample strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idx_reg <= 4'h8;
      acc_l_reg <= '0;
      acc_r_reg <= '0;
      left <= '0;
      right <= '0;
    end else if (strobe) begin
      idx_reg <= 4'h0;
      acc_l_reg <= '0;
      acc_r_reg <= '0;
    end else if (idx_reg < 4'h8) begin
      idx_reg <= idx_reg + 4'h1;
      acc_l_reg <= acc_l_reg + part_l;
      acc_r_reg <= acc_r_reg + part_r;
    end else if (idx_reg == 4'h8) begin
      idx_reg <= 4'h9;
      // Scale by 2^21 (three 7-bit gains) plus 3 bits of eight-way headroom
      left <= W'(out_l >>> 24);
      right <= W'(out_r >>> 24);
    end
  end
endmodule

// ---- verilog/mpmc_top.sv ----
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/10ps
// Contract
// - Patch only to a channel of same sampling frequency; reject others
// - One track may feed many channels; any permutation allowed
// - Patch indicator lit when mapping is not identity
// - Routed channels go out on the selected port and slot board; OUT_PORT always carries them, the CTRL select bit drives nothing
// - Confidence mode: tracks play off-tape unless input monitor is on
// - Off-tape audio lags the input by about 240 ms
// - Confidence mode: arm key of a base pair arms both tracks
// - Confidence mode: either key of an armed pair disarms both
// - Dual and quad rate tracks arm individually
// - Entering confidence mode disarms all tracks
// - Outside confidence mode arming is per track
// - First key press flashes; second within 5 s enters, else stops
// - In confidence mode one key press exits at once
// - Mixdown sums eight sources to stereo on channels 7 and 8
// - Mixdown key toggles; channels 1 to 6 silent while on
// - Mixdown only allowed with all eight tracks at base rate
// - Each mix slot selects source and channel; slots are fixed
// - Invalid mix source during mixdown raises error until escape
// - Channel level 0-127, pan, independent master level
// - Mix settings silent until mixdown is on
// - Clock key steps the word-sync source and lights its lamp
// - Unusable clock source flashes its lamp and raises error
module mpmc_top #(
  parameter int W = 24,
  parameter int unsigned CONFIRM_CYC = mpmc_pkg::CONFIRM_CYC,
  parameter int LAG_DEPTH = mpmc_pkg::LAG_SAMPLES_48K
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire mpmc_pkg::mpmc_keys_t KEYS,
  input wire logic SAMPLE_STB,
  input wire logic [8*W-1:0] TAPE_IN,
  input wire logic [8*W-1:0] SRC_IN,
  input wire logic [8*W-1:0] SLOT_IN,
  input wire logic [8*W-1:0] DIG_IN,
  input wire logic DIG_CONNECTED,
  input wire logic [4:0] CLK_OK_PIN,
  output logic [8*W-1:0] OUT_PORT,
  output logic [8*W-1:0] SLOT_OUT,
  output logic [7:0] ARM_LAMP,
  output logic PATCH_LAMP,
  output logic CONF_LAMP,
  output logic MIX_LAMP,
  output logic [4:0] CLK_LAMP,
  output logic MIX_ERR,
  output logic CLK_ERR,
  output logic PATCH_REJ
);
  typedef enum {C_IDLE, C_ARMED, C_ACTIVE} mpmc_conf_t;

  // ******************************************************
  // Registers
  // ******************************************************
  mpmc_conf_t conf_reg, conf_next;
  logic [27:0] win_reg;
  logic [23:0] flash_reg;
  logic blink_reg;
  logic [23:0] patch_reg;
  logic [15:0] rate_reg;
  logic [7:0] inmon_reg;
  logic [7:0] arm_reg, arm_next;
  logic mix_reg;
  logic out_sel_reg;
  logic [6:0] master_reg;
  logic mixerr_reg;
  logic rej_reg;
  mpmc_pkg::mpmc_clk_t clk_sel_reg;
  mpmc_pkg::mpmc_mixsel_t [7:0] msel_reg;
  mpmc_pkg::mpmc_mixch_t [7:0] mch_reg;
  logic [4:0] ok_s1_reg, ok_s2_reg;

  // ******************************************************
  // Bus decode
  // ******************************************************
  wire wr_ctrl = WR && ADDR == mpmc_pkg::OFS_CTRL;
  wire wr_rate = WR && ADDR == mpmc_pkg::OFS_RATE;
  wire wr_patch = WR && ADDR == mpmc_pkg::OFS_PATCH;
  wire wr_inmon = WR && ADDR == mpmc_pkg::OFS_INMON;
  wire wr_master = WR && ADDR == mpmc_pkg::OFS_MASTER;
  wire wr_msel = WR && ADDR[7:5] == 3'h1 && ADDR[1:0] == 2'h0;
  wire wr_mch = WR && ADDR[7:5] == 3'h2 && ADDR[1:0] == 2'h0;
  wire [2:0] widx = ADDR[4:2];

  // ******************************************************
  // Patch check: each channel's new track must share its rate
  // ******************************************************
  logic patch_ok;
  logic patch_ident;
  always_comb begin
    patch_ok = 1'b1;
    for (int c = 0; c < 8; c++) begin
      if (rate_reg[2*c +: 2] != rate_reg[2*WDATA[3*c +: 3] +: 2]) begin
        patch_ok = 1'b0;
      end
    end
  end
  assign patch_ident = patch_reg == mpmc_pkg::PATCH_RST;

  wire all_base = rate_reg == 16'h0000;
  wire mix_allowed = all_base;

  // ******************************************************
  // Confidence key sequence
  // ******************************************************
  wire win_done = win_reg >= 28'(CONFIRM_CYC - 1);
  always_comb begin
    conf_next = conf_reg;
    case (conf_reg)
      C_IDLE: if (KEYS.confidence) conf_next = C_ARMED;
      C_ARMED: begin
        if (KEYS.confidence) begin
          conf_next = C_ACTIVE;
        end else if (win_done) begin
          conf_next = C_IDLE;
        end
      end
      C_ACTIVE: if (KEYS.confidence) conf_next = C_IDLE;
      default: conf_next = C_IDLE;
    endcase
  end
  wire conf_on = conf_reg == C_ACTIVE;
  wire conf_enter = conf_next == C_ACTIVE && conf_reg != C_ACTIVE;

  // ******************************************************
  // Arming: pairs for base tracks in confidence mode only
  // ******************************************************
  always_comb begin
    arm_next = arm_reg;
    if (conf_enter) begin
      arm_next = 8'h00;
    end else begin
      for (int t = 0; t < 8; t++) begin
        if (KEYS.arm[t]) begin
          if (conf_on && rate_reg[2*t +: 2] == 2'h0 &&
              rate_reg[2*(t^1) +: 2] == 2'h0) begin
            // Either key toggles the pair as one unit
            arm_next[t] = ~arm_reg[t & 6];
            arm_next[t^1] = ~arm_reg[t & 6];
          end else begin
            arm_next[t] = ~arm_reg[t];
          end
        end
      end
    end
  end

  // ******************************************************
  // Monitor selection with off-tape lag
  // ******************************************************
  logic [8*W-1:0] tape_lag;
  logic [8*W-1:0] mon;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_trk
      mpmc_delay #(.W(W), .DEPTH(LAG_DEPTH)) u_lag (
        .clk(CORE_CLK),
        .rst(RST),
        .strobe(SAMPLE_STB),
        .din(TAPE_IN[g*W +: W]),
        .dout(tape_lag[g*W +: W])
      );
      // Confidence: off-tape unless input monitor on
      assign mon[g*W +: W] = (!conf_on || inmon_reg[g]) ?
        SRC_IN[g*W +: W] : tape_lag[g*W +: W];
    end
  endgenerate

  // ******************************************************
  // Mix source selection
  // ******************************************************
  logic [8*W-1:0] mix_in;
  logic mix_bad;
  always_comb begin
    mix_bad = 1'b0;
    for (int s = 0; s < 8; s++) begin
      case (msel_reg[s].src)
        mpmc_pkg::MPMC_TAPE: mix_in[s*W +: W] = mon[msel_reg[s].chan*W +: W];
        mpmc_pkg::MPMC_SLOT:
          mix_in[s*W +: W] = SLOT_IN[msel_reg[s].chan*W +: W];
        mpmc_pkg::MPMC_DIG: begin
          mix_in[s*W +: W] = DIG_IN[msel_reg[s].chan*W +: W];
          if (!DIG_CONNECTED) mix_bad = 1'b1;
        end
        default: begin
          mix_in[s*W +: W] = '0;
          mix_bad = 1'b1;
        end
      endcase
    end
  end

  logic [W-1:0] mix_l, mix_r;
  mpmc_mixer #(.W(W)) u_mix (
    .clk(CORE_CLK),
    .rst(RST),
    .strobe(SAMPLE_STB),
    .mix_in(mix_in),
    .chan_cfg(mch_reg),
    .master(master_reg),
    .left(mix_l),
    .right(mix_r)
  );

  // ******************************************************
  // Output routing
  // ******************************************************
  logic [8*W-1:0] routed;
  always_comb begin
    for (int c = 0; c < 8; c++) begin
      routed[c*W +: W] = mon[patch_reg[3*c +: 3]*W +: W];
    end
    if (mix_reg) begin
      // Summer only reaches the outputs with mixdown on
      routed[6*W-1:0] = '0;
      routed[6*W +: W] = mix_l;
      routed[7*W +: W] = mix_r;
    end
  end

  // ******************************************************
  // Clock source status
  // ******************************************************
  wire [4:0] ok_now = ok_s2_reg;
  wire clk_bad = !ok_now[clk_sel_reg];
  wire [4:0] sel_hot = 5'h01 << clk_sel_reg;

  // ******************************************************
  // Sequential state
  // ******************************************************
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      conf_reg <= C_IDLE;
      win_reg <= '0;
      arm_reg <= 8'h00;
      patch_reg <= mpmc_pkg::PATCH_RST;
      rate_reg <= 16'h0000;
      inmon_reg <= 8'h00;
      mix_reg <= 1'b0;
      out_sel_reg <= 1'b0;
      master_reg <= mpmc_pkg::LEVEL_RST;
      mixerr_reg <= 1'b0;
      rej_reg <= 1'b0;
      clk_sel_reg <= mpmc_pkg::MPMC_INT;
      ok_s1_reg <= 5'h1F; // No false clock error while filling
      ok_s2_reg <= 5'h1F;
      flash_reg <= '0;
      blink_reg <= 1'b0;
    end else begin
      conf_reg <= conf_next;
      win_reg <= (conf_reg == C_ARMED) ? win_reg + 28'h1 : '0;
      arm_reg <= arm_next;
      ok_s1_reg <= CLK_OK_PIN;
      ok_s2_reg <= ok_s1_reg;
      flash_reg <= (flash_reg >= 24'(mpmc_pkg::FLASH_CYC - 1)) ?
        '0 : flash_reg + 24'h1;
      if (flash_reg == '0) blink_reg <= ~blink_reg;
      if (wr_rate) rate_reg <= WDATA[15:0];
      if (wr_inmon) inmon_reg <= WDATA[7:0];
      if (wr_master) master_reg <= WDATA[6:0];
      if (wr_ctrl) out_sel_reg <= WDATA[0];
      if (wr_patch) begin
        rej_reg <= !patch_ok;
        if (patch_ok) patch_reg <= WDATA[23:0];
      end
      if (KEYS.mixdown) begin
        mix_reg <= !mix_reg && mix_allowed;
      end else if (!mix_allowed) begin
        mix_reg <= 1'b0;
      end
      // Set wins over the escape clear
      if (mix_reg && mix_bad) begin
        mixerr_reg <= 1'b1;
      end else if (KEYS.escape) begin
        mixerr_reg <= 1'b0;
      end
      if (KEYS.clock) begin
        clk_sel_reg <= (clk_sel_reg == mpmc_pkg::MPMC_SLOTCK) ?
          mpmc_pkg::MPMC_INT : mpmc_pkg::mpmc_clk_t'(clk_sel_reg + 3'h1);
      end
    end
  end

  // Mix tables have no reset need beyond defaults
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      for (int s = 0; s < 8; s++) begin
        msel_reg[s] <= {mpmc_pkg::MPMC_TAPE, 3'(s)};
        mch_reg[s] <= {mpmc_pkg::LEVEL_RST, mpmc_pkg::PAN_CENTER};
      end
    end else begin
      if (wr_msel) msel_reg[widx] <= WDATA[4:0];
      if (wr_mch) mch_reg[widx] <= {WDATA[14:8], WDATA[6:0]};
    end
  end

  // ******************************************************
  // Outputs and read-back
  // ******************************************************
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (ADDR == mpmc_pkg::OFS_CTRL) rd_mux = {31'h0, out_sel_reg};
    else if (ADDR == mpmc_pkg::OFS_RATE) rd_mux = {16'h0, rate_reg};
    else if (ADDR == mpmc_pkg::OFS_PATCH) rd_mux = {8'h0, patch_reg};
    else if (ADDR == mpmc_pkg::OFS_INMON) rd_mux = {24'h0, inmon_reg};
    else if (ADDR == mpmc_pkg::OFS_STATUS)
      rd_mux = {22'h0, rej_reg, clk_bad, mixerr_reg, mix_reg,
        clk_sel_reg, conf_reg == C_ARMED, conf_on, !patch_ident};
    else if (ADDR == mpmc_pkg::OFS_ARM) rd_mux = {24'h0, arm_reg};
    else if (ADDR == mpmc_pkg::OFS_MASTER) rd_mux = {25'h0, master_reg};
    else if (ADDR == mpmc_pkg::OFS_CLKOK) rd_mux = {27'h0, ok_now};
    else if (ADDR[7:5] == 3'h1) rd_mux = {27'h0, msel_reg[widx]};
    else if (ADDR[7:5] == 3'h2)
      rd_mux = {17'h0, mch_reg[widx].level, 1'b0, mch_reg[widx].pan};
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      RDATA <= 32'h0;
      OUT_PORT <= '0;
      SLOT_OUT <= '0;
      ARM_LAMP <= 8'h00;
      PATCH_LAMP <= 1'b0;
      CONF_LAMP <= 1'b0;
      MIX_LAMP <= 1'b0;
      CLK_LAMP <= 5'h01;
      MIX_ERR <= 1'b0;
      CLK_ERR <= 1'b0;
      PATCH_REJ <= 1'b0;
    end else begin
      RDATA <= RD ? rd_mux : 32'h0;
      // Both routes carry the same channels; port choice is external
      OUT_PORT <= routed;
      SLOT_OUT <= routed;
      ARM_LAMP <= arm_reg;
      PATCH_LAMP <= !patch_ident;
      CONF_LAMP <= conf_on || (conf_reg == C_ARMED && blink_reg);
      MIX_LAMP <= mix_reg;
      CLK_LAMP <= (clk_bad && !blink_reg) ? 5'h00 : sel_hot;
      MIX_ERR <= mixerr_reg;
      CLK_ERR <= clk_bad;
      PATCH_REJ <= rej_reg;
    end
  end
endmodule

// ---- tb/mpmc_top_asserts.sv ----
`timescale 1ns/10ps
// ****************************************************
// Port checker for the control block
// ****************************************************
module mpmc_top_asserts #(
  parameter int W = 24
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire mpmc_pkg::mpmc_keys_t KEYS,
  input wire logic [8*W-1:0] OUT_PORT,
  input wire logic [8*W-1:0] SLOT_OUT,
  input wire logic [7:0] ARM_LAMP,
  input wire logic PATCH_LAMP,
  input wire logic MIX_LAMP,
  input wire logic [4:0] CLK_LAMP,
  input wire logic MIX_ERR,
  input wire logic CLK_ERR,
  input wire logic PATCH_REJ
);
  // Bus and key events that may legally move the lamps
  wire patch_wr = WR && (ADDR == mpmc_pkg::OFS_PATCH);
  wire ident_wr = patch_wr && (WDATA[23:0] == mpmc_pkg::PATCH_RST);
  wire arm_cause = (|KEYS.arm) || KEYS.confidence || WR;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  // Output copies, mixdown silence and clock lamps
  a_slot_mirror: assert property (OUT_PORT == SLOT_OUT)
    else $error("slot copy differs from port output");
  a_mix_silent: assert property (MIX_LAMP && $past(MIX_LAMP)
    && $past(MIX_LAMP, 2) |-> OUT_PORT[6*W-1:0] == '0)
    else $error("channels 1 to 6 carry signal in mixdown");
  a_clk_single: assert property ($onehot0(CLK_LAMP))
    else $error("more than one clock lamp lit");
  a_clk_lit: assert property (!CLK_ERR && !$past(CLK_ERR)
    |-> $onehot(CLK_LAMP))
    else $error("no clock lamp lit without clock error");
  a_clk_hold: assert property (!$past(KEYS.clock)
    && !$past(KEYS.clock, 2) && !CLK_ERR && !$past(CLK_ERR)
    |-> $stable(CLK_LAMP))
    else $error("clock lamp moved without clock key");
  // Mix error sets only in mixdown and holds until escape
  a_mixerr_cause: assert property ($rose(MIX_ERR)
    |-> MIX_LAMP || $past(MIX_LAMP))
    else $error("mix error raised outside mixdown");
  a_mixerr_hold: assert property (MIX_ERR && !KEYS.escape
    && !$past(KEYS.escape) |=> MIX_ERR)
    else $error("mix error dropped without escape");
  a_mixerr_fall: assert property ($fell(MIX_ERR)
    |-> $past(KEYS.escape) || $past(KEYS.escape, 2))
    else $error("mix error cleared without escape");
  // Patch rejection and identity lamp follow patch writes; arm lamps follow keys or writes
  a_rej_cause: assert property ($rose(PATCH_REJ)
    |-> $past(patch_wr) || $past(patch_wr, 2))
    else $error("patch reject without patch write");
  a_ident_dark: assert property (ident_wr |-> ##3 !PATCH_LAMP)
    else $error("patch lamp lit after identity patch");
  a_arm_cause: assert property ($changed(ARM_LAMP)
    |-> $past(arm_cause) || $past(arm_cause, 2) || $past(arm_cause, 3))
    else $error("arm lamps moved without key or write");
endmodule

// ---- tb/mpmc_far_model.sv ----
`timescale 1ns/10ps
// ****************************************************
// Far side: audio sources, sample pacing, clock health
// ****************************************************
module mpmc_far_model #(
  parameter int W = 24
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] ok_mask,
  output logic stb,
  output logic [8*W-1:0] tape,
  output logic [8*W-1:0] src,
  output logic [8*W-1:0] slot,
  output logic [8*W-1:0] dig,
  output logic [4:0] clk_ok
);
  logic [3:0] div_reg;
  logic [15:0] cnt_reg;

  // Strobe every 16 cycles; data moves with the strobe and holds
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_reg <= 4'h0;
      cnt_reg <= 16'h0000;
      stb <= 1'b0;
    end else begin
      div_reg <= div_reg + 4'h1;
      stb <= (div_reg == 4'hF);
      if (div_reg == 4'hF) begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end

  // Source, channel and sample count make every word traceable
  always_comb begin
    for (int c = 0; c < 8; c++) begin
      tape[c*W +: W] = W'({4'h1, 4'(c), cnt_reg});
      src[c*W +: W] = W'({4'h2, 4'(c), cnt_reg});
      slot[c*W +: W] = W'({4'h3, 4'(c), cnt_reg});
      dig[c*W +: W] = W'({4'h4, 4'(c), cnt_reg});
    end
  end

  // Health pins are asynchronous, so lag them off the edge
  assign #3 clk_ok = ok_mask;
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
// ****************************************************
// Bench for the monitor, patch and mixdown control
// ****************************************************
module tb_top;
  localparam int W = 24;
  localparam logic [11:0] CONF = 12'h800;
  localparam logic [11:0] MIX = 12'h400;
  localparam logic [11:0] CLKK = 12'h200;
  localparam logic [11:0] ESC = 12'h100;
  logic clk, rst, wr, rd, dig_conn, stb;
  logic [7:0] addr, arm_lamp;
  logic [31:0] wdata, rdata;
  mpmc_pkg::mpmc_keys_t keys;
  logic [4:0] ok_mask, clk_ok, clk_lamp;
  logic patch_lamp, conf_lamp, mix_lamp, mix_err, clk_err, patch_rej;
  logic [8*W-1:0] tape_in, src_in, slot_in, dig_in, out_port, slot_out;
  int num_errors = 0;
  int comparisons = 0;

  mpmc_top #(.W(W), .CONFIRM_CYC(20), .LAG_DEPTH(4)) u_mpmc_top (
    .CORE_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .KEYS(keys), .SAMPLE_STB(stb),
    .TAPE_IN(tape_in), .SRC_IN(src_in), .SLOT_IN(slot_in),
    .DIG_IN(dig_in), .DIG_CONNECTED(dig_conn), .CLK_OK_PIN(clk_ok),
    .OUT_PORT(out_port), .SLOT_OUT(slot_out), .ARM_LAMP(arm_lamp),
    .PATCH_LAMP(patch_lamp), .CONF_LAMP(conf_lamp), .MIX_LAMP(mix_lamp),
    .CLK_LAMP(clk_lamp), .MIX_ERR(mix_err), .CLK_ERR(clk_err),
    .PATCH_REJ(patch_rej));
  mpmc_far_model #(.W(W)) u_mpmc_far_model (.clk(clk), .rst(rst),
    .ok_mask(ok_mask), .stb(stb), .tape(tape_in), .src(src_in),
    .slot(slot_in), .dig(dig_in), .clk_ok(clk_ok));

  // ****************************************************
  // Shared helpers
  // ****************************************************
  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask
  function automatic logic [31:0] ch(input logic [8*W-1:0] v, input int n);
    return 32'(v[n*W +: W]);
  endfunction
  // Let the edge's updates land before anything is sampled
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    tick(1);
    rd <= 1'b0;
    d = rdata;
  endtask
  task key(input logic [11:0] k);
    @(posedge clk);
    keys <= mpmc_pkg::mpmc_keys_t'(k);
    @(posedge clk);
    keys <= '0;
    tick(3);
  endtask
  // Park well after a sample strobe so routing and mixer have settled
  task mid;
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (stb !== 1'b1 && i < 40);
    if (i >= 40) begin
      num_errors++;
      conclude;
    end
    tick(13);
  endtask

  // ****************************************************
  // Scenarios
  // ****************************************************
  task t_reset;
    logic [31:0] d;
    chk(clk_lamp, 32'h01);
    bus_rd(mpmc_pkg::OFS_STATUS, d);
    chk(d, 32'h0);
    bus_rd(mpmc_pkg::OFS_PATCH, d);
    chk(d, 32'h00FAC688);
    bus_rd(8'hFC, d);
    chk(d, 32'h0);
    bus_wr(mpmc_pkg::OFS_MASTER, 32'h55);
    bus_rd(mpmc_pkg::OFS_MASTER, d);
    chk(d, 32'h55);
    $display("reset test done");
  endtask
  task t_patch;
    logic [31:0] d;
    bus_wr(mpmc_pkg::OFS_RATE, 32'h0);
    bus_wr(mpmc_pkg::OFS_INMON, 32'hFF);
    bus_wr(mpmc_pkg::OFS_PATCH, 32'h00FEC650);
    mid;
    chk(patch_lamp, 32'h1);
    chk(ch(out_port, 1), ch(src_in, 2));
    chk(ch(out_port, 2), ch(src_in, 1));
    chk(ch(out_port, 6), ch(src_in, 7));
    chk(ch(slot_out, 7), ch(src_in, 7));
    // Track 2 goes dual rate, then channel 1 may not take it
    bus_wr(mpmc_pkg::OFS_RATE, 32'h4);
    bus_wr(mpmc_pkg::OFS_PATCH, 32'h00FAC689);
    tick(3);
    chk(patch_rej, 32'h1);
    bus_rd(mpmc_pkg::OFS_PATCH, d);
    chk(d, 32'h00FEC650);
    bus_wr(mpmc_pkg::OFS_PATCH, 32'(mpmc_pkg::PATCH_RST));
    tick(3);
    chk({patch_lamp, patch_rej}, 32'h0);
    $display("patch test done");
  endtask
  task t_conf;
    logic [31:0] d;
    bus_wr(mpmc_pkg::OFS_RATE, 32'h5000);
    key(12'h001);
    chk(arm_lamp, 32'h01);
    key(CONF);
    bus_rd(mpmc_pkg::OFS_STATUS, d);
    chk(d[2:1], 32'h2);
    chk(conf_lamp, 32'h1);
    tick(25);
    bus_rd(mpmc_pkg::OFS_STATUS, d);
    chk(d[2:1], 32'h0);
    key(CONF);
    key(CONF);
    bus_rd(mpmc_pkg::OFS_STATUS, d);
    chk(d[2:1], 32'h1);
    chk(arm_lamp, 32'h0);
    bus_wr(mpmc_pkg::OFS_INMON, 32'hFE);
    mid;
    chk(ch(out_port, 0), ch(tape_in, 0) - 32'h4);
    chk(ch(out_port, 1), ch(src_in, 1));
    key(12'h008);
    chk(arm_lamp, 32'h0C);
    key(12'h004);
    chk(arm_lamp, 32'h0);
    key(12'h040);
    chk(arm_lamp, 32'h40);
    key(12'h001);
    chk(arm_lamp, 32'h43);
    key(CONF);
    chk(conf_lamp, 32'h0);
    key(12'h002);
    chk(arm_lamp, 32'h41);
    $display("confidence test done");
  endtask
  task t_mix;
    key(MIX);
    chk(mix_lamp, 32'h0);
    bus_wr(mpmc_pkg::OFS_RATE, 32'h0);
    for (int n = 0; n < 8; n++) begin
      bus_wr(mpmc_pkg::OFS_MIXSRC + 8'(4*n), 32'(n));
      bus_wr(mpmc_pkg::OFS_MIXLVL + 8'(4*n), 32'h0040);
    end
    bus_wr(mpmc_pkg::OFS_MIXLVL, 32'h7F00);
    bus_wr(mpmc_pkg::OFS_MASTER, 32'h7F);
    mid;
    chk(ch(out_port, 7), ch(src_in, 7));
    key(MIX);
    chk(mix_lamp, 32'h1);
    mid;
    for (int n = 0; n < 6; n++) begin
      chk(ch(out_port, n), 32'h0);
    end
    chk(ch(out_port, 7), 32'h0);
    chk(ch(out_port, 6) != 32'h0, 32'h1);
    bus_wr(mpmc_pkg::OFS_MIXLVL, 32'h7F7F);
    mid;
    chk(ch(out_port, 6), 32'h0);
    chk(ch(out_port, 7) != 32'h0, 32'h1);
    // Digital source while disconnected stays flagged until escape
    bus_wr(mpmc_pkg::OFS_MIXSRC + 8'hC, 32'h13);
    tick(4);
    chk(mix_err, 32'h1);
    bus_wr(mpmc_pkg::OFS_MIXSRC + 8'hC, 32'h3);
    tick(4);
    chk(mix_err, 32'h1);
    key(ESC);
    chk(mix_err, 32'h0);
    @(posedge clk);
    dig_conn <= 1'b1;
    bus_wr(mpmc_pkg::OFS_MIXSRC + 8'hC, 32'h13);
    tick(4);
    chk(mix_err, 32'h0);
    key(MIX);
    chk(mix_lamp, 32'h0);
    $display("mixdown test done");
  endtask
  task t_clock;
    for (int i = 0; i < 5; i++) begin
      key(CLKK);
      chk(clk_lamp, 32'(1 << ((i + 1) % 5)));
    end
    @(posedge clk);
    ok_mask <= 5'h1D;
    key(CLKK);
    for (int i = 0; i < 10 && clk_err !== 1'b1; i++) begin
      tick(1);
    end
    chk(clk_err, 32'h1);
    @(posedge clk);
    ok_mask <= 5'h1F;
    repeat (4) key(CLKK);
    key(ESC);
    chk(clk_lamp, 32'h01);
    $display("clock test done");
  endtask

  // Clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #2000000;
    num_errors++;
    conclude;
  end
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    keys = '0;
    dig_conn = 1'b0;
    ok_mask = 5'h1F;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    t_reset;
    t_patch;
    t_conf;
    t_mix;
    t_clock;
    conclude;
  end
endmodule

bind mpmc_top mpmc_top_asserts #(.W(W)) u_mpmc_top_asserts (.*);
